// ==== rtl/udtb_base_regs.sv ====
// Purpose: descriptor table base address registers behind an APB slave
// Assumes: single clock, synchronous active-low reset
// Notes:   zero-wait APB; unmapped access answers with pslverr
//
// Operation
// - the low page register holds bits 15..9 of the base in its bits 7..1.
// - bit 0 of the low page register reads zero and ignores writes.
// - the mid page register holds bits 23..16 of the base in its bits 7..0.
// - the high page register holds bits 31..24 of the base in its bits 7..0.
// - the base is 32 bits with bits 8..0 always zero, giving 512-byte alignment.
// - the assembled base is the table start handed to the descriptor logic.
// - bits 31..8 of each register read zero and ignore writes.
// - every field bit is read/write and clears to zero at reset.
`timescale 1ns/1ns
module udtb_base_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] tableBase
);
	// =========================================================
	// bus decode
	logic        setupPh;
	logic        wrLow;
	logic        wrMid;
	logic        wrHigh;
	logic [6:0]  lowField;
	logic [7:0]  midField;
	logic [7:0]  highField;
	logic [31:0] rdData;
	logic        hit;
	logic        byte0;
	logic        accessPh;
	logic        wrAccess;

	// response is registered at setup, so pready stands for the access cycle only
	assign setupPh  = psel && !penable;
	// a write lands at the edge that completes the transfer, never at setup,
	// so a setup that is never completed cannot disturb a field
	assign accessPh = psel && penable && pready;
	assign wrAccess = accessPh && pwrite;
	assign byte0    = pstrb[0];
	// only the low byte lane carries storage; other lanes are dropped
	assign wrLow  = wrAccess && byte0 && (paddr == udtb_pkg::OFS_PAGE_LOW);
	assign wrMid  = wrAccess && byte0 && (paddr == udtb_pkg::OFS_PAGE_MID);
	assign wrHigh = wrAccess && byte0 && (paddr == udtb_pkg::OFS_PAGE_HIGH);

	// =========================================================
	// storage
	udtb_field_reg #(.W(udtb_pkg::LOW_FIELD_W), .RST_VAL(udtb_pkg::RST_LOW)) u_low (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrLow),
		.wrData (pwdata[7:1]),
		.value  (lowField)
	);
	udtb_field_reg #(.W(udtb_pkg::BYTE_FIELD_W), .RST_VAL(udtb_pkg::RST_BYTE)) u_mid (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrMid),
		.wrData (pwdata[7:0]),
		.value  (midField)
	);
	udtb_field_reg #(.W(udtb_pkg::BYTE_FIELD_W), .RST_VAL(udtb_pkg::RST_BYTE)) u_high (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (wrHigh),
		.wrData (pwdata[7:0]),
		.value  (highField)
	);

	udtb_rd_mux u_mux (
		.addr      (paddr),
		.lowField  (lowField),
		.midField  (midField),
		.highField (highField),
		.rdData    (rdData),
		.hit       (hit)
	);

	// =========================================================
	// response registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setupPh;
			pslverr <= setupPh && !hit;
			// read data captured at setup and held through the access cycle
			prdata  <= (setupPh && !pwrite) ? rdData : 32'h0000_0000;
		end
	end

	// =========================================================
	// base address to descriptor logic, registered one cycle after the field
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tableBase <= 32'h0000_0000;
		end else begin
			tableBase <= {highField, midField, lowField, udtb_pkg::ALIGN_ZERO};
		end
	end

	// =========================================================
	// checks
	sequence s_wrLow;
		psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_LOW;
	endsequence

	sequence s_wrMid;
		psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_MID;
	endsequence

	sequence s_wrHigh;
		psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_HIGH;
	endsequence

	property p_low_store;
		@(posedge clk) disable iff (!rst_n)
		s_wrLow |=> ##1 (tableBase[15:9] == $past(pwdata[7:1], 2));
	endproperty
	a_low_store: assert property (p_low_store) else $error("low field not stored");

	property p_bit0_zero;
		@(posedge clk) disable iff (!rst_n)
		pready && paddr == 8'h00 |-> prdata[0] == 1'b0;
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("bit 0 read nonzero");

	property p_mid_store;
		@(posedge clk) disable iff (!rst_n)
		s_wrMid |=> ##1 (tableBase[23:16] == $past(pwdata[7:0], 2));
	endproperty
	a_mid_store: assert property (p_mid_store) else $error("mid field not stored");

	property p_high_store;
		@(posedge clk) disable iff (!rst_n)
		s_wrHigh |=> ##1 (tableBase[31:24] == $past(pwdata[7:0], 2));
	endproperty
	a_high_store: assert property (p_high_store) else $error("high field not stored");

	property p_align;
		@(posedge clk) disable iff (!rst_n)
		tableBase[8:0] == 9'h000;
	endproperty
	a_align: assert property (p_align) else $error("base not aligned");

	property p_base_follows;
		@(posedge clk) disable iff (!rst_n)
		$stable(lowField) && $stable(midField) && $stable(highField)
		|=> $stable(tableBase);
	endproperty
	a_base_follows: assert property (p_base_follows) else $error("base moved");

	property p_upper_zero;
		@(posedge clk) disable iff (!rst_n)
		pready |-> prdata[31:8] == 24'h00_0000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper bits nonzero");

	property p_reset_clear;
		@(posedge clk)
		!rst_n |=> tableBase == 32'h0000_0000 && prdata == 32'h0000_0000;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset not clear");

	property p_readback;
		@(posedge clk) disable iff (!rst_n)
		(psel && !penable && !pwrite && paddr == 8'h04) |=> prdata[7:0] == $past(midField);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	// =========================================================
	// handshake checks
	sequence s_setupUnmapped;
		psel && !penable && paddr != udtb_pkg::OFS_PAGE_LOW
		&& paddr != udtb_pkg::OFS_PAGE_MID && paddr != udtb_pkg::OFS_PAGE_HIGH;
	endsequence

	sequence s_rdLow;
		psel && !penable && !pwrite && paddr == udtb_pkg::OFS_PAGE_LOW;
	endsequence

	sequence s_rdHigh;
		psel && !penable && !pwrite && paddr == udtb_pkg::OFS_PAGE_HIGH;
	endsequence

	sequence s_noLowWr;
		!(psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_LOW);
	endsequence

	sequence s_noMidWr;
		!(psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_MID);
	endsequence

	sequence s_noHighWr;
		!(psel && penable && pready && pwrite && pstrb[0] && paddr == udtb_pkg::OFS_PAGE_HIGH);
	endsequence

	property p_ready_answer;
		@(posedge clk) disable iff (!rst_n)
		psel && !penable |=> pready;
	endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("no answer after setup");

	property p_ready_pulse;
		@(posedge clk) disable iff (!rst_n)
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_err_with_ready;
		@(posedge clk) disable iff (!rst_n)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

	property p_err_unmapped;
		@(posedge clk) disable iff (!rst_n)
		s_setupUnmapped |=> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not flagged");

	property p_idle_zero;
		@(posedge clk) disable iff (!rst_n)
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside access");

	property p_wr_rdata_zero;
		@(posedge clk) disable iff (!rst_n)
		psel && !penable && pwrite |=> prdata == 32'h0000_0000;
	endproperty
	a_wr_rdata_zero: assert property (p_wr_rdata_zero) else $error("read data on write");

	// =========================================================
	// field checks
	property p_rd_low;
		@(posedge clk) disable iff (!rst_n)
		s_rdLow |=> prdata[7:0] == {$past(lowField), 1'b0};
	endproperty
	a_rd_low: assert property (p_rd_low) else $error("low readback mismatch");

	property p_rd_high;
		@(posedge clk) disable iff (!rst_n)
		s_rdHigh |=> prdata[7:0] == $past(highField);
	endproperty
	a_rd_high: assert property (p_rd_high) else $error("high readback mismatch");

	property p_low_lands;
		@(posedge clk) disable iff (!rst_n)
		s_wrLow |=> lowField == $past(pwdata[7:1]);
	endproperty
	a_low_lands: assert property (p_low_lands) else $error("low write lost");

	property p_mid_lands;
		@(posedge clk) disable iff (!rst_n)
		s_wrMid |=> midField == $past(pwdata[7:0]);
	endproperty
	a_mid_lands: assert property (p_mid_lands) else $error("mid write lost");

	property p_high_lands;
		@(posedge clk) disable iff (!rst_n)
		s_wrHigh |=> highField == $past(pwdata[7:0]);
	endproperty
	a_high_lands: assert property (p_high_lands) else $error("high write lost");

	// a setup alone must never move a field
	property p_setup_keeps;
		@(posedge clk) disable iff (!rst_n)
		psel && !penable
		|=> $stable(lowField) && $stable(midField) && $stable(highField);
	endproperty
	a_setup_keeps: assert property (p_setup_keeps) else $error("field moved at setup");

	property p_strb_ignored;
		@(posedge clk) disable iff (!rst_n)
		psel && penable && pready && pwrite && !pstrb[0]
		|=> $stable(lowField) && $stable(midField) && $stable(highField);
	endproperty
	a_strb_ignored: assert property (p_strb_ignored) else $error("masked write landed");

	property p_low_keeps;
		@(posedge clk) disable iff (!rst_n)
		s_noLowWr |=> $stable(lowField);
	endproperty
	a_low_keeps: assert property (p_low_keeps) else $error("low field disturbed");

	property p_mid_keeps;
		@(posedge clk) disable iff (!rst_n)
		s_noMidWr |=> $stable(midField);
	endproperty
	a_mid_keeps: assert property (p_mid_keeps) else $error("mid field disturbed");

	property p_high_keeps;
		@(posedge clk) disable iff (!rst_n)
		s_noHighWr |=> $stable(highField);
	endproperty
	a_high_keeps: assert property (p_high_keeps) else $error("high field disturbed");

	property p_fields_reset;
		@(posedge clk)
		!rst_n |=> lowField == 7'h00 && midField == 8'h00 && highField == 8'h00;
	endproperty
	a_fields_reset: assert property (p_fields_reset) else $error("field not cleared");

	property p_base_track;
		@(posedge clk) disable iff (!rst_n)
		tableBase[31:9] == $past({highField, midField, lowField});
	endproperty
	a_base_track: assert property (p_base_track) else $error("base not from fields");
endmodule // udtb_base_regs

// ==== pkg/udtb_pkg.sv ====
// Purpose: constants for the descriptor table base register bank
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets chosen for this bank; unused bits read as zero
package udtb_pkg;
	// =========================================================
	// register map
	localparam logic [7:0]  OFS_PAGE_LOW   = 8'h00;
	localparam logic [7:0]  OFS_PAGE_MID   = 8'h04;
	localparam logic [7:0]  OFS_PAGE_HIGH  = 8'h08;
	localparam int          ADDR_W         = 8;
	// =========================================================
	// field layout
	localparam int          LOW_FIELD_LSB  = 1;
	localparam int          LOW_FIELD_W    = 7;
	localparam int          BYTE_FIELD_W   = 8;
	localparam int          BASE_LOW_LSB   = 9;
	localparam int          BASE_MID_LSB   = 16;
	localparam int          BASE_HIGH_LSB  = 24;
	// =========================================================
	// reset values
	localparam logic [6:0]  RST_LOW        = 7'h00;
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [8:0]  ALIGN_ZERO     = 9'h000;
endpackage

// ==== rtl/udtb_field_reg.sv ====
// Purpose: one software-writable field with synchronous clear
// Assumes: write strobe is a single-cycle pulse
// Notes:   width set by parameter
`timescale 1ns/1ns
module udtb_field_reg #(
	parameter int           W        = 8,
	parameter logic [W-1:0] RST_VAL  = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         wrEn,
	input  wire logic [W-1:0] wrData,
	output logic      [W-1:0] value
);
	if (W < 1) begin : g_bad_width
		$error("udtb_field_reg: W must be positive");
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			value <= RST_VAL;
		end else if (wrEn) begin
			value <= wrData;
		end
	end
endmodule // udtb_field_reg

// ==== rtl/udtb_rd_mux.sv ====
// Purpose: read-back selection for the three page registers
// Assumes: address already word aligned by the caller
// Notes:   unmapped addresses read as zero
`timescale 1ns/1ns
module udtb_rd_mux (
	input  wire logic [7:0]  addr,
	input  wire logic [6:0]  lowField,
	input  wire logic [7:0]  midField,
	input  wire logic [7:0]  highField,
	output logic      [31:0] rdData,
	output logic             hit
);
	always_comb begin
		rdData = 32'h0000_0000;
		hit    = 1'b1;
		case (addr)
			udtb_pkg::OFS_PAGE_LOW:  rdData = {24'h00_0000, lowField, 1'b0};
			udtb_pkg::OFS_PAGE_MID:  rdData = {24'h00_0000, midField};
			udtb_pkg::OFS_PAGE_HIGH: rdData = {24'h00_0000, highField};
			default:                 hit = 1'b0;
		endcase
	end
endmodule // udtb_rd_mux

// ==== sim/udtb_base_regs_tb.sv ====
// Purpose: self-checking bench for the descriptor base register bank
// Assumes: zero-wait APB slave, write lands at the access edge
// Notes:   expectations come from a mirror of the three fields
`timescale 1ns/1ns
module udtb_base_regs_tb;
	// =========================================================
	// signals
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, errSeen;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, tableBase, rnd, rdVal;
	logic [3:0]  pstrb;
	logic [7:0]  mirror [3];
	int          num_errors, cmp_count, idx;

	udtb_base_regs uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tableBase(tableBase));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// =========================================================
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// unmapped slot and unused bits read as zero
	function automatic logic [31:0] expRd(input int i);
		return (i < 3) ? {24'h00_0000, mirror[i]} : 32'h0000_0000;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// request held until the rising edge that samples pready high; answer taken there
	task automatic doOp(input logic wr, input int i, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= 8'(4 * i);
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			num_errors++;
		rdVal   = prdata;
		errSeen = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pslverr", 32'(errSeen), 32'(i == 3));
		if (!wr)
			chk("read data", rdVal, expRd(i));
		if (!wr && i == 0)
			chk("low bit 0", 32'(rdVal[0]), 32'h0);
		if (wr && i < 3 && s[0])
			mirror[i] = (i == 0) ? (d[7:0] & 8'hFE) : d[7:0];
		// field lands at the access edge, the base one edge later
		repeat (2) @(posedge clk);
		chk("base 15:9", 32'(tableBase[15:9]), 32'(mirror[0][7:1]));
		chk("base 23:16", 32'(tableBase[23:16]), 32'(mirror[1]));
		chk("base 31:24", 32'(tableBase[31:24]), 32'(mirror[2]));
		chk("base 8:0", 32'(tableBase[8:0]), 32'h0);
	endtask

	// =========================================================
	// sequence
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
		mirror = '{default: 8'h00};
		num_errors = 0;
		cmp_count = 0;
		rnd = 32'hBCEDB51C;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (idx = 0; idx < 3; idx++)
			doOp(1'b0, idx, 32'h0, 4'hF);
		for (idx = 0; idx < 4; idx++)
			doOp(1'b1, idx, 32'hFFFFFFFF, 4'hF);
		for (idx = 0; idx < 4; idx++)
			doOp(1'b0, idx, 32'h0, 4'hF);
		doOp(1'b1, 1, 32'h0000005A, 4'hE);
		repeat (60) begin
			rnd = lfsr(rnd);
			doOp(rnd[2], int'(rnd[1:0]), lfsr(rnd), rnd[6:3]);
		end
		// reset in mid-run: every field must come back as zero
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		mirror = '{default: 8'h00};
		for (idx = 0; idx < 3; idx++)
			doOp(1'b0, idx, 32'h0, 4'hF);
		give_verdict();
	end

	initial begin
		// about 75 transfers of five cycles each need under 10 us
		#40000;
		num_errors++;
		give_verdict();
	end
endmodule // udtb_base_regs_tb
